// *** ppc_checker.sv ***
// Protection checker: segment, page and gate checks for one reference a cycle.
// Assumes the execution unit drives REQ on CLK_SYS and honours commit/fault.
`timescale 1ns/1ps
module ppc_checker
(
  // Clock and reset
  input  wire  logic              CLK_SYS,
  input  wire  logic              RST,
  // Reference from the execution unit
  input  wire  logic              REQ_VALID,
  input  wire  ppc_pkg::ppc_req_s REQ,
  // Verdict, one cycle later
  output logic                    RSP_VALID,
  output ppc_pkg::ppc_rsp_s       RSP,
  output logic [1:0]              CPL,
  // AXI4-Lite write
  input  wire  logic              S_AXI_AWVALID,
  output logic                    S_AXI_AWREADY,
  input  wire  logic [3:0]        S_AXI_AWADDR,
  input  wire  logic              S_AXI_WVALID,
  output logic                    S_AXI_WREADY,
  input  wire  logic [31:0]       S_AXI_WDATA,
  input  wire  logic [3:0]        S_AXI_WSTRB,
  output logic                    S_AXI_BVALID,
  input  wire  logic              S_AXI_BREADY,
  output logic [1:0]              S_AXI_BRESP,
  // AXI4-Lite read
  input  wire  logic              S_AXI_ARVALID,
  output logic                    S_AXI_ARREADY,
  input  wire  logic [3:0]        S_AXI_ARADDR,
  output logic                    S_AXI_RVALID,
  input  wire  logic              S_AXI_RREADY,
  output logic [31:0]             S_AXI_RDATA,
  output logic [1:0]              S_AXI_RRESP
);

  // ==========================================================================
  // State
  logic [1:0]              cpl_r;
  logic                    page_en_r;
  logic                    sticky_r;
  ppc_pkg::ppc_cause_t     last_cause_r;
  logic [31:0]             faddr_r;
  logic [31:0]             fcount_r;
  logic                    rsp_valid_r;
  ppc_pkg::ppc_rsp_s       rsp_r;
  ppc_pkg::ppc_rsp_s       rsp_nxt;

  logic                    f_sys;
  logic                    f_gate;
  logic                    f_priv;
  logic                    f_lim;
  logic                    f_type;
  logic                    f_rights;
  logic                    f_pgp;
  logic                    f_pgw;
  logic                    is_mem;
  logic                    is_code;
  logic                    is_data;
  logic                    seg_ok;

  assign CPL       = cpl_r;
  assign RSP_VALID = rsp_valid_r;
  assign RSP       = rsp_r;

  // ==========================================================================
  // Combinational checks
  always_comb
  begin
    f_sys    = 1'b0;
    f_gate   = 1'b0;
    f_priv   = 1'b0;
    f_lim    = 1'b0;
    f_type   = 1'b0;
    f_rights = 1'b0;
    f_pgp    = 1'b0;
    f_pgw    = 1'b0;
    is_code  = REQ.dtype == ppc_pkg::DT_CODE;
    is_data  = REQ.dtype == ppc_pkg::DT_DATA;
    is_mem   = (REQ.op == ppc_pkg::OP_READ) || (REQ.op == ppc_pkg::OP_WRITE)
               || (REQ.op == ppc_pkg::OP_FETCH);
    rsp_nxt           = '0;
    rsp_nxt.new_cpl   = cpl_r;
    rsp_nxt.entry_off = REQ.offset;
    case (REQ.op)
      ppc_pkg::OP_READ, ppc_pkg::OP_WRITE, ppc_pkg::OP_FETCH:
      begin
        f_priv   = cpl_r > REQ.dpl;
        f_lim    = REQ.offset > REQ.limit;
        f_type   = !(is_code || is_data) || (REQ.op == ppc_pkg::OP_FETCH && !is_code)
                   || (REQ.op == ppc_pkg::OP_WRITE && is_code);
        f_rights = (REQ.op == ppc_pkg::OP_READ && is_code && !REQ.rw)
                   || (REQ.op == ppc_pkg::OP_WRITE && is_data && !REQ.rw);
      end
      ppc_pkg::OP_SYSLOAD:
        f_sys = cpl_r != ppc_pkg::PL_MOST;
      ppc_pkg::OP_FAR_DIRECT:
      begin
        f_priv = REQ.dpl < cpl_r;
        f_lim  = REQ.offset > REQ.limit;
        f_type = !is_code;
      end
      ppc_pkg::OP_INT_GATE, ppc_pkg::OP_CALL_GATE:
      begin
        f_type = REQ.dtype != ((REQ.op == ppc_pkg::OP_INT_GATE) ? ppc_pkg::DT_TRAPGT
                                                                : ppc_pkg::DT_CALLGT);
        // caller at least as privileged as gate
        f_gate = cpl_r > REQ.dpl;
        // An outward call through a gate is never allowed.
        f_priv = REQ.tgt_dpl > cpl_r;
        rsp_nxt.entry_sel = REQ.gate_sel;
        rsp_nxt.entry_off = REQ.gate_off;
        rsp_nxt.new_cpl   = REQ.tgt_dpl;
        rsp_nxt.stack_sw  = REQ.tgt_dpl < cpl_r;
        rsp_nxt.stack_pl  = REQ.tgt_dpl;
        if (REQ.op == ppc_pkg::OP_CALL_GATE && REQ.tgt_dpl < cpl_r)
          rsp_nxt.copy_cnt = REQ.gate_count;
      end
      ppc_pkg::OP_TASK_SW:
      begin
        // target must be a task record
        f_type          = REQ.dtype != ppc_pkg::DT_TASKREC;
        rsp_nxt.new_cpl = REQ.tgt_dpl;
      end
      default:
        f_type = 1'b1;
    endcase
    seg_ok = !(f_sys || f_gate || f_priv || f_lim || f_type || f_rights);
    if (is_mem && page_en_r && seg_ok)
    begin
      // supervisor pages need level 0 to 2
      f_pgp = !REQ.pg_user && cpl_r == ppc_pkg::PL_LEAST;
      f_pgw = REQ.op == ppc_pkg::OP_WRITE && REQ.pg_user && !REQ.pg_writable;
    end
    // any violation aborts with a protection fault
    if (f_sys)
      rsp_nxt.cause = ppc_pkg::C_SYSREG;
    else if (f_gate)
      rsp_nxt.cause = ppc_pkg::C_GATE;
    else if (f_priv)
      rsp_nxt.cause = ppc_pkg::C_PRIV;
    else if (f_lim)
      rsp_nxt.cause = ppc_pkg::C_LIMIT;
    else if (f_type)
      rsp_nxt.cause = ppc_pkg::C_TYPE;
    else if (f_rights)
      rsp_nxt.cause = ppc_pkg::C_RIGHTS;
    else if (f_pgp)
      rsp_nxt.cause = ppc_pkg::C_PG_PRIV;
    else if (f_pgw)
      rsp_nxt.cause = ppc_pkg::C_PG_WR;
    else
      rsp_nxt.cause = ppc_pkg::C_NONE;
    rsp_nxt.fault = rsp_nxt.cause != ppc_pkg::C_NONE;
    rsp_nxt.commit = !rsp_nxt.fault;
    if (rsp_nxt.fault)
    begin
      rsp_nxt.new_cpl  = cpl_r;
      rsp_nxt.stack_sw = 1'b0;
      rsp_nxt.copy_cnt = '0;
    end
  end

  // ==========================================================================
  // Verdict register
  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      rsp_valid_r <= 1'b0;
      rsp_r       <= '0;
    end
    else
    begin
      rsp_valid_r <= REQ_VALID;
      if (REQ_VALID)
        rsp_r <= rsp_nxt;
    end
  end

  // Current level follows gate and task switch targets, not far direct transfers; faults leave it alone.
  // level of the code entered through a gate or task switch
  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
      cpl_r <= ppc_pkg::CPL_RESET;
    else if (REQ_VALID && rsp_nxt.commit && (REQ.op == ppc_pkg::OP_INT_GATE
             || REQ.op == ppc_pkg::OP_CALL_GATE || REQ.op == ppc_pkg::OP_TASK_SW))
      cpl_r <= rsp_nxt.new_cpl;
  end

  // ==========================================================================
  // Fault log
  logic aw_have_r;
  logic w_have_r;
  logic [3:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic bvalid_r;
  logic rvalid_r;
  logic wr_fire;
  logic clr_sticky;

  assign wr_fire    = aw_have_r && w_have_r && !bvalid_r;
  assign clr_sticky = wr_fire && awaddr_r == ppc_pkg::REG_STATUS && wstrb_r[1]
                      && wdata_r[ppc_pkg::STAT_STICKY_BIT];

  // A fault in the cycle of the clear keeps the flag set.
  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      sticky_r     <= 1'b0;
      last_cause_r <= ppc_pkg::C_NONE;
      faddr_r      <= '0;
      fcount_r     <= '0;
    end
    else if (REQ_VALID && rsp_nxt.fault)
    begin
      sticky_r     <= 1'b1;
      last_cause_r <= rsp_nxt.cause;
      faddr_r      <= REQ.offset;
      fcount_r     <= fcount_r + 32'h1;
    end
    else if (clr_sticky)
      sticky_r <= 1'b0;
  end

  // ==========================================================================
  // AXI4-Lite slave: address and data taken in either order, one write at a time
  assign S_AXI_AWREADY = !aw_have_r;
  assign S_AXI_WREADY  = !w_have_r;
  assign S_AXI_BVALID  = bvalid_r;
  assign S_AXI_ARREADY = !rvalid_r;
  assign S_AXI_RVALID  = rvalid_r;

  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      aw_have_r   <= 1'b0;
      w_have_r    <= 1'b0;
      awaddr_r    <= '0;
      wdata_r     <= '0;
      wstrb_r     <= '0;
      bvalid_r    <= 1'b0;
      S_AXI_BRESP <= ppc_pkg::RESP_OKAY;
    end
    else
    begin
      if (S_AXI_AWVALID && !aw_have_r)
      begin
        aw_have_r <= 1'b1;
        awaddr_r  <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && !w_have_r)
      begin
        w_have_r <= 1'b1;
        wdata_r  <= S_AXI_WDATA;
        wstrb_r  <= S_AXI_WSTRB;
      end
      if (wr_fire)
      begin
        bvalid_r    <= 1'b1;
        S_AXI_BRESP <= (awaddr_r == ppc_pkg::REG_CTRL || awaddr_r == ppc_pkg::REG_STATUS)
                       ? ppc_pkg::RESP_OKAY : ppc_pkg::RESP_SLVERR;
      end
      else if (bvalid_r && S_AXI_BREADY)
      begin
        bvalid_r  <= 1'b0;
        aw_have_r <= 1'b0;
        w_have_r  <= 1'b0;
      end
    end
  end

  // Control register: page checks on or off.
  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
      page_en_r <= ppc_pkg::CTRL_PAGE_EN_RESET;
    else if (wr_fire && awaddr_r == ppc_pkg::REG_CTRL && wstrb_r[0])
      page_en_r <= wdata_r[ppc_pkg::CTRL_PAGE_EN_BIT];
  end

  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      rvalid_r    <= 1'b0;
      S_AXI_RDATA <= '0;
      S_AXI_RRESP <= ppc_pkg::RESP_OKAY;
    end
    else if (S_AXI_ARVALID && !rvalid_r)
    begin
      rvalid_r    <= 1'b1;
      S_AXI_RRESP <= ppc_pkg::RESP_OKAY;
      S_AXI_RDATA <= '0;
      case (S_AXI_ARADDR)
        ppc_pkg::REG_CTRL:
          S_AXI_RDATA[ppc_pkg::CTRL_PAGE_EN_BIT] <= page_en_r;
        ppc_pkg::REG_STATUS:
        begin
          S_AXI_RDATA[ppc_pkg::STAT_CPL_LSB +: 2]   <= cpl_r;
          S_AXI_RDATA[ppc_pkg::STAT_CAUSE_LSB +: 4] <= last_cause_r;
          S_AXI_RDATA[ppc_pkg::STAT_STICKY_BIT]     <= sticky_r;
        end
        ppc_pkg::REG_FADDR:
          S_AXI_RDATA <= faddr_r;
        ppc_pkg::REG_FCOUNT:
          S_AXI_RDATA <= fcount_r;
        default:
          S_AXI_RRESP <= ppc_pkg::RESP_SLVERR;
      endcase
    end
    else if (rvalid_r && S_AXI_RREADY)
      rvalid_r <= 1'b0;
  end

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);

  sequence s_mem_req;
    REQ_VALID && (REQ.op == ppc_pkg::OP_READ || REQ.op == ppc_pkg::OP_WRITE
                  || REQ.op == ppc_pkg::OP_FETCH);
  endsequence

  sequence s_inward_call;
    REQ_VALID && REQ.op == ppc_pkg::OP_CALL_GATE && REQ.dtype == ppc_pkg::DT_CALLGT
    && cpl_r <= REQ.dpl && REQ.tgt_dpl < cpl_r;
  endsequence

  a_sysload_level: assert property (
    REQ_VALID && REQ.op == ppc_pkg::OP_SYSLOAD && cpl_r != ppc_pkg::PL_MOST
    |=> RSP_VALID && RSP.fault && RSP.cause == ppc_pkg::C_SYSREG)
    else $error("system load below level 0 not faulted");

  a_seg_privilege: assert property (
    s_mem_req ##0 cpl_r > REQ.dpl |=> RSP.fault && RSP.cause == ppc_pkg::C_PRIV)
    else $error("segment privilege violation not faulted");

  a_seg_limit: assert property (
    s_mem_req ##0 (cpl_r <= REQ.dpl && REQ.offset > REQ.limit)
    |=> RSP_VALID && RSP.cause == ppc_pkg::C_LIMIT)
    else $error("limit violation not faulted");

  a_code_write: assert property (
    REQ_VALID && REQ.op == ppc_pkg::OP_WRITE && REQ.dtype == ppc_pkg::DT_CODE
    |=> RSP.fault)
    else $error("write to code segment accepted");

  a_task_type: assert property (
    REQ_VALID && REQ.op == ppc_pkg::OP_TASK_SW && REQ.dtype != ppc_pkg::DT_TASKREC
    |=> RSP.fault && $stable(cpl_r))
    else $error("task switch to non-record accepted");

  a_page_super: assert property (
    s_mem_req ##0 (page_en_r && !REQ.pg_user && cpl_r == ppc_pkg::PL_LEAST)
    |=> RSP.fault)
    else $error("supervisor page reached from level 3");

  a_gate_stack: assert property (
    s_inward_call |=> RSP.stack_sw && RSP.copy_cnt == $past(REQ.gate_count)
    && cpl_r == $past(REQ.tgt_dpl))
    else $error("inward call gate did not switch stack or copy");

  a_fault_norestore: assert property (
    REQ_VALID && rsp_nxt.fault |=> !RSP.commit && cpl_r == $past(cpl_r))
    else $error("faulting reference changed state");

  a_direct_inward: assert property (
    REQ_VALID && REQ.op == ppc_pkg::OP_FAR_DIRECT && REQ.dpl < cpl_r
    |=> RSP.fault && cpl_r == $past(cpl_r))
    else $error("direct inward transfer accepted");

endmodule : ppc_checker

// *** ppc_exec_model.sv ***
// Execution unit model: presents one reference to the checker per cycle of go.
// Assumes the bench drives go and req_in by non-blocking assignment on CLK_SYS.
`timescale 1ns/1ps
module ppc_exec_model
(
  // Clock and reset
  input  wire  logic              CLK_SYS,
  input  wire  logic              RST,
  // Bench side
  input  wire  logic              go,
  input  wire  ppc_pkg::ppc_req_s req_in,
  // Checker side
  output logic                    REQ_VALID,
  output ppc_pkg::ppc_req_s       REQ
);
  // ==========================================================================
  // Issue
  // Between references the payload is inverted, so a checker that reads a
  // stale payload without its valid is caught.
  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      REQ_VALID <= 1'b0;
      REQ       <= '0;
    end
    else
    begin
      REQ_VALID <= go;
      REQ       <= go ? req_in : ~REQ;
    end
  end
endmodule : ppc_exec_model

// *** ppc_pkg.sv ***
// Constants, types and register map of the privilege protection checker.
// Assumes one core clock, and requests from the execution unit on that same clock.
// What this block does
// - Privilege has four levels; 0 most privileged, 3 least.
// - Current level comes from the code segment being executed; a far direct transfer leaves it unchanged.
// - Use of a more privileged segment or page aborts with protection fault.
// - System register loads run only at level 0, else fault.
// - Every segment reference is checked, data accesses and instruction fetches alike.
// - Segment access needs current level numerically at most the segment level.
// - Offset beyond the descriptor limit faults, leaving the instruction restartable.
// - Descriptor type is checked against the operation; writes to code fault.
// - A task switch target must be a task state record, else fault.
// - Code is execute or execute-read; data is read or read-write.
// - User pages match level 3; supervisor pages need level 0, 1 or 2.
// - Writes to read-only user pages are rejected.
// - Page checks run only after all segment checks have passed.
// - Direct call or jump into more privileged code faults.
// - Gate entry point is the gate's stored logical address and level.
// - A gate is usable only by callers at least as privileged.
// - Trap gate entered by software interrupt, call gate by far call.
// - Gate call inward raises level and switches to that level's stack.
// - Call gate copies its count of 32-bit parameters to the new stack.
package ppc_pkg;

  // ==========================================================================
  // Privilege levels
  // two-bit privilege level
  localparam logic [1:0] PL_MOST  = 2'h0;
  localparam logic [1:0] PL_LEAST = 2'h3;
  localparam logic [1:0] CPL_RESET = 2'h0;

  // ==========================================================================
  // Register map, byte addresses on the AXI4-Lite slave
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_FADDR  = 4'h8;
  localparam logic [3:0] REG_FCOUNT = 4'hC;
  localparam int CTRL_PAGE_EN_BIT  = 0;
  localparam logic CTRL_PAGE_EN_RESET = 1'b0;
  localparam int STAT_CPL_LSB      = 0;
  localparam int STAT_CAUSE_LSB    = 4;
  localparam int STAT_STICKY_BIT   = 8;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================================
  // Operations presented by the execution unit
  typedef enum logic [2:0] {
    OP_READ       = 3'h0,
    OP_WRITE      = 3'h1,
    OP_FETCH      = 3'h2,
    OP_SYSLOAD    = 3'h3,
    OP_FAR_DIRECT = 3'h4,
    OP_INT_GATE   = 3'h5,
    OP_CALL_GATE  = 3'h6,
    OP_TASK_SW    = 3'h7
  } ppc_op_e;

  // Descriptor type codes
  localparam logic [2:0] DT_DATA    = 3'h0;
  localparam logic [2:0] DT_CODE    = 3'h1;
  localparam logic [2:0] DT_TRAPGT  = 3'h2;
  localparam logic [2:0] DT_CALLGT  = 3'h3;
  localparam logic [2:0] DT_TASKREC = 3'h4;

  // Fault causes, lowest code checked first
  typedef logic [3:0] ppc_cause_t;
  localparam ppc_cause_t C_NONE    = 4'h0;
  localparam ppc_cause_t C_SYSREG  = 4'h1;
  localparam ppc_cause_t C_GATE    = 4'h2;
  localparam ppc_cause_t C_PRIV    = 4'h3;
  localparam ppc_cause_t C_LIMIT   = 4'h4;
  localparam ppc_cause_t C_TYPE    = 4'h5;
  localparam ppc_cause_t C_RIGHTS  = 4'h6;
  localparam ppc_cause_t C_PG_PRIV = 4'h7;
  localparam ppc_cause_t C_PG_WR   = 4'h8;

  typedef struct packed {
    ppc_op_e     op;
    logic [31:0] offset;
    logic [1:0]  dpl;
    logic [2:0]  dtype;
    logic        rw;
    logic [31:0] limit;
    logic        pg_user;
    logic        pg_writable;
    logic [15:0] gate_sel;
    logic [31:0] gate_off;
    logic [4:0]  gate_count;
    logic [1:0]  tgt_dpl;
  } ppc_req_s;

  typedef struct packed {
    logic        fault;
    ppc_cause_t  cause;
    logic        commit;
    logic [1:0]  new_cpl;
    logic        stack_sw;
    logic [1:0]  stack_pl;
    logic [4:0]  copy_cnt;
    logic [15:0] entry_sel;
    logic [31:0] entry_off;
  } ppc_rsp_s;

endpackage : ppc_pkg

// *** tb_top.sv ***
// Testbench of the protection checker: references through the model, registers over AXI4-Lite.
// Assumes each verdict comes exactly one cycle after its reference is taken.
`timescale 1ns/1ps
module tb_top;
  // ==========================================================================
  // Signals
  typedef struct {
    ppc_pkg::ppc_op_e    op;
    logic [1:0]          dpl;
    logic [2:0]          dt;
    logic                rw;
    logic                f;
    ppc_pkg::ppc_cause_t c;
  } ppc_tcase_s;
  logic              clk_sys = 1'b0;
  logic              rst = 1'b1;
  logic              go = 1'b0;
  ppc_pkg::ppc_req_s req_in = '0;
  logic              req_valid, rsp_valid, awready, wready, bvalid, arready, rvalid;
  ppc_pkg::ppc_req_s req;
  ppc_pkg::ppc_rsp_s rsp;
  logic [1:0]        cpl, bresp, rresp;
  logic              awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [3:0]        awaddr = 4'h0, araddr = 4'h0, wstrb = 4'h0;
  logic [31:0]       wdata = 32'h0, rdata, last_foff;
  int                n_errors = 0, total_checks = 0, cycles = 0, n_faults = 0;
  // Every reference here is made at level 3.
  ppc_tcase_s seg_tab[12] = '{
    '{ppc_pkg::OP_READ, 2'h2, ppc_pkg::DT_DATA, 1'b0, 1'b1, ppc_pkg::C_PRIV},
    '{ppc_pkg::OP_READ, 2'h3, ppc_pkg::DT_DATA, 1'b0, 1'b0, ppc_pkg::C_NONE},
    '{ppc_pkg::OP_FETCH, 2'h3, ppc_pkg::DT_CODE, 1'b0, 1'b0, ppc_pkg::C_NONE},
    '{ppc_pkg::OP_FETCH, 2'h0, ppc_pkg::DT_CODE, 1'b0, 1'b1, ppc_pkg::C_PRIV},
    '{ppc_pkg::OP_FETCH, 2'h3, ppc_pkg::DT_DATA, 1'b1, 1'b1, ppc_pkg::C_TYPE},
    '{ppc_pkg::OP_WRITE, 2'h3, ppc_pkg::DT_CODE, 1'b1, 1'b1, ppc_pkg::C_TYPE},
    '{ppc_pkg::OP_READ, 2'h3, ppc_pkg::DT_CODE, 1'b0, 1'b1, ppc_pkg::C_RIGHTS},
    '{ppc_pkg::OP_READ, 2'h3, ppc_pkg::DT_CODE, 1'b1, 1'b0, ppc_pkg::C_NONE},
    '{ppc_pkg::OP_WRITE, 2'h3, ppc_pkg::DT_DATA, 1'b0, 1'b1, ppc_pkg::C_RIGHTS},
    '{ppc_pkg::OP_WRITE, 2'h3, ppc_pkg::DT_DATA, 1'b1, 1'b0, ppc_pkg::C_NONE},
    '{ppc_pkg::OP_FAR_DIRECT, 2'h0, ppc_pkg::DT_CODE, 1'b1, 1'b1, ppc_pkg::C_PRIV},
    '{ppc_pkg::OP_FAR_DIRECT, 2'h3, ppc_pkg::DT_CODE, 1'b1, 1'b0, ppc_pkg::C_NONE}};

  // ==========================================================================
  // Instances
  ppc_exec_model i_ppc_exec_model
  (
    .CLK_SYS(clk_sys), .RST(rst), .go(go), .req_in(req_in), .REQ_VALID(req_valid), .REQ(req)
  );
  ppc_checker i_ppc_checker
  (
    .CLK_SYS(clk_sys), .RST(rst), .REQ_VALID(req_valid), .REQ(req),
    .RSP_VALID(rsp_valid), .RSP(rsp), .CPL(cpl),
    .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_AWADDR(awaddr),
    .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb),
    .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_BRESP(bresp),
    .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_ARADDR(araddr),
    .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp)
  );

  // ==========================================================================
  // Clock, timeout and report
  always #20 clk_sys = ~clk_sys;
  // A hang anywhere ends the run here; the whole sequence needs well under a thousand cycles.
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      n_errors++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    $display("Checks %0d, errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // ==========================================================================
  // Bus and reference tasks
  task automatic axw(input logic [3:0] a, input logic [31:0] d, output logic [1:0] resp);
    logic ha, hw, done;
    @(posedge clk_sys);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= d;
    wstrb <= 4'hF;
    bready <= 1'b1;
    done = 1'b0;
    while (!done)
    begin
      #1;
      ha = awvalid && awready;
      hw = wvalid && wready;
      done = bvalid;
      resp = bresp;
      @(posedge clk_sys);
      if (ha) awvalid <= 1'b0;
      if (hw) wvalid <= 1'b0;
    end
    bready <= 1'b0;
  endtask : axw
  task automatic axr(input logic [3:0] a, output logic [31:0] d, output logic [1:0] resp);
    logic ha, done;
    @(posedge clk_sys);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    done = 1'b0;
    while (!done)
    begin
      #1;
      ha = arvalid && arready;
      done = rvalid;
      d = rdata;
      resp = rresp;
      @(posedge clk_sys);
      if (ha) arvalid <= 1'b0;
    end
    rready <= 1'b0;
  endtask : axr
  function automatic ppc_pkg::ppc_req_s mk(ppc_pkg::ppc_op_e op, logic [1:0] dpl, logic [2:0] dt, logic rw);
    ppc_pkg::ppc_req_s r;
    r = '0;
    r.op = op;
    r.dpl = dpl;
    r.dtype = dt;
    r.rw = rw;
    r.offset = 32'h0000_0100;
    r.limit = 32'h0000_0FFF;
    r.pg_user = 1'b1;
    r.pg_writable = 1'b1;
    return r;
  endfunction : mk
  task automatic issue(input ppc_pkg::ppc_req_s r, input logic f, input ppc_pkg::ppc_cause_t c,
                       input logic [1:0] ecpl);
    @(posedge clk_sys);
    go <= 1'b1;
    req_in <= r;
    @(posedge clk_sys);
    go <= 1'b0;
    @(posedge clk_sys);
    #1;
    chk(rsp_valid, 1'b1);
    chk(rsp.fault, f);
    chk(rsp.cause, c);
    chk(rsp.commit, !f);
    chk(cpl, ecpl);
    chk(rsp.new_cpl, ecpl);
    if (f)
    begin
      n_faults++;
      last_foff = r.offset;
    end
    @(posedge clk_sys);
    #1;
    chk(rsp_valid, 1'b0);
  endtask : issue
  task automatic tsw(input logic [1:0] lvl);
    ppc_pkg::ppc_req_s r;
    r = mk(ppc_pkg::OP_TASK_SW, 2'h3, ppc_pkg::DT_TASKREC, 1'b0);
    r.tgt_dpl = lvl;
    issue(r, 1'b0, ppc_pkg::C_NONE, lvl);
  endtask : tsw

  // ==========================================================================
  // Scenarios
  task automatic t_reset();
    logic [31:0] d;
    logic [1:0]  b;
    @(posedge clk_sys);
    #1;
    chk(rsp_valid, 1'b0);
    chk(cpl, ppc_pkg::CPL_RESET);
    axr(ppc_pkg::REG_CTRL, d, b);
    chk(d, 32'h0000_0000);
    axr(ppc_pkg::REG_FCOUNT, d, b);
    chk(d, 32'h0000_0000);
  endtask : t_reset
  task automatic t_task();
    ppc_pkg::ppc_req_s r;
    ppc_pkg::ppc_req_s s;
    s = mk(ppc_pkg::OP_SYSLOAD, 2'h0, ppc_pkg::DT_CODE, 1'b1);
    issue(s, 1'b0, ppc_pkg::C_NONE, 2'h0);
    r = mk(ppc_pkg::OP_TASK_SW, 2'h3, ppc_pkg::DT_DATA, 1'b0);
    r.tgt_dpl = 2'h3;
    issue(r, 1'b1, ppc_pkg::C_TYPE, 2'h0);
    r.dtype = ppc_pkg::DT_TASKREC;
    // Back to back: the second reference must already see the level the first one set.
    @(posedge clk_sys);
    go <= 1'b1;
    req_in <= r;
    @(posedge clk_sys);
    req_in <= s;
    @(posedge clk_sys);
    go <= 1'b0;
    #1;
    chk(rsp.commit, 1'b1);
    chk(cpl, 2'h3);
    @(posedge clk_sys);
    #1;
    chk(rsp.cause, ppc_pkg::C_SYSREG);
    n_faults++;
    last_foff = s.offset;
  endtask : t_task
  task automatic t_segment();
    ppc_pkg::ppc_req_s r;
    foreach (seg_tab[i])
      issue(mk(seg_tab[i].op, seg_tab[i].dpl, seg_tab[i].dt, seg_tab[i].rw),
            seg_tab[i].f, seg_tab[i].c, 2'h3);
    r = mk(ppc_pkg::OP_READ, 2'h3, ppc_pkg::DT_DATA, 1'b0);
    r.offset = r.limit;
    issue(r, 1'b0, ppc_pkg::C_NONE, 2'h3);
    r.offset = r.limit + 32'h1;
    issue(r, 1'b1, ppc_pkg::C_LIMIT, 2'h3);
  endtask : t_segment
  task automatic t_gates();
    ppc_pkg::ppc_req_s r;
    r = mk(ppc_pkg::OP_CALL_GATE, 2'h3, ppc_pkg::DT_CALLGT, 1'b0);
    r.gate_count = 5'h05;
    r.gate_sel = 16'h0028;
    r.gate_off = 32'h0000_1234;
    issue(r, 1'b0, ppc_pkg::C_NONE, 2'h0);
    chk(rsp.stack_sw, 1'b1);
    chk(rsp.stack_pl, 2'h0);
    chk(rsp.copy_cnt, 5'h05);
    chk(rsp.entry_sel, 16'h0028);
    chk(rsp.entry_off, 32'h0000_1234);
    tsw(2'h3);
    r.op = ppc_pkg::OP_INT_GATE;
    r.dtype = ppc_pkg::DT_TRAPGT;
    r.tgt_dpl = 2'h1;
    issue(r, 1'b0, ppc_pkg::C_NONE, 2'h1);
    chk(rsp.stack_pl, 2'h1);
    chk(rsp.copy_cnt, 5'h00);
    r.dtype = ppc_pkg::DT_CALLGT;
    issue(r, 1'b1, ppc_pkg::C_TYPE, 2'h1);
    r.op = ppc_pkg::OP_CALL_GATE;
    r.dpl = 2'h0;
    issue(r, 1'b1, ppc_pkg::C_GATE, 2'h1);
    r.dpl = 2'h1;
    issue(r, 1'b0, ppc_pkg::C_NONE, 2'h1);
    chk(rsp.stack_sw, 1'b0);
    chk(rsp.copy_cnt, 5'h00);
    r.tgt_dpl = 2'h3;
    issue(r, 1'b1, ppc_pkg::C_PRIV, 2'h1);
  endtask : t_gates
  task automatic t_page();
    ppc_pkg::ppc_req_s r;
    logic [31:0]       d;
    logic [1:0]        b;
    axw(ppc_pkg::REG_CTRL, 32'h0000_0001, b);
    chk(b, ppc_pkg::RESP_OKAY);
    axr(ppc_pkg::REG_CTRL, d, b);
    chk(d, 32'h0000_0001);
    tsw(2'h3);
    r = mk(ppc_pkg::OP_READ, 2'h3, ppc_pkg::DT_DATA, 1'b1);
    r.pg_user = 1'b0;
    issue(r, 1'b1, ppc_pkg::C_PG_PRIV, 2'h3);
    r.offset = r.limit + 32'h1;
    issue(r, 1'b1, ppc_pkg::C_LIMIT, 2'h3);
    r.offset = 32'h0000_0200;
    r.op = ppc_pkg::OP_WRITE;
    r.pg_user = 1'b1;
    r.pg_writable = 1'b0;
    issue(r, 1'b1, ppc_pkg::C_PG_WR, 2'h3);
    r.pg_writable = 1'b1;
    issue(r, 1'b0, ppc_pkg::C_NONE, 2'h3);
    tsw(2'h2);
    r.pg_user = 1'b0;
    r.pg_writable = 1'b0;
    issue(r, 1'b0, ppc_pkg::C_NONE, 2'h2);
    axw(ppc_pkg::REG_CTRL, 32'h0000_0000, b);
    tsw(2'h3);
    issue(r, 1'b0, ppc_pkg::C_NONE, 2'h3);
  endtask : t_page
  task automatic t_regs();
    logic [31:0] d;
    logic [1:0]  b;
    axr(ppc_pkg::REG_FCOUNT, d, b);
    chk(d, 32'(n_faults));
    axr(ppc_pkg::REG_FADDR, d, b);
    chk(d, last_foff);
    axr(ppc_pkg::REG_STATUS, d, b);
    chk(d & 32'h0000_0103, 32'h0000_0103);
    axw(ppc_pkg::REG_STATUS, 32'h0000_0100, b);
    axr(ppc_pkg::REG_STATUS, d, b);
    chk(d & 32'h0000_0103, 32'h0000_0003);
    axw(ppc_pkg::REG_FADDR, 32'hFFFF_FFFF, b);
    chk(b, ppc_pkg::RESP_SLVERR);
    axr(ppc_pkg::REG_FADDR, d, b);
    chk(d, last_foff);
    axr(4'h2, d, b);
    chk(b, ppc_pkg::RESP_SLVERR);
  endtask : t_regs

  // ==========================================================================
  // Main sequence
  initial
  begin
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    t_reset();
    t_task();
    t_segment();
    t_gates();
    t_page();
    t_regs();
    report_and_stop();
  end
endmodule : tb_top
